// ==== src/ais_ctrl.v ====
// Converter control: registers, input/reference decode, conversion sequencer.
// Assumes a single clock, synchronous active-low reset, converter core outside.
// Analog switches, amplifier and bandgap sit outside; only their selects live here.
// Pin requests come from the port logic and are taken as synchronous.
`timescale 1ns/1ns
`include "ais_regs.vh"

module ais_ctrl #(
  parameter NUM_PINS = 4
) (
  // Clock, reset, enable
  input  wire                mclk,
  input  wire                rst_n,
  input  wire                clk_en,
  // Register port
  input  wire [2:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  // Converter core
  input  wire [11:0]         core_result,
  output reg                 core_power,
  output reg                 core_sample,
  output reg                 core_clk_tick,
  output reg                 core_done,
  // Analog input multiplexer (one-hot)
  output reg  [4:0]          ext_channel_onehot,
  output reg  [6:0]          internal_source_onehot,
  // Reference and amplifier
  output reg  [2:0]          reference_onehot,
  output reg                 ext_ref_pin_connect,
  output reg                 amplifier_enable,
  output reg                 amp_ref_input_pin_connect,
  output reg                 amp_bandgap_connect,
  output reg  [3:0]          amplifier_gain_onehot,
  output reg                 bandgap_enable,
  // Pin overrides
  input  wire [NUM_PINS-1:0] pin_analog_select,
  input  wire [NUM_PINS-1:0] pin_pull_high_req,
  input  wire [NUM_PINS-1:0] pin_output_en_req,
  output reg  [NUM_PINS-1:0] pin_pull_high,
  output reg  [NUM_PINS-1:0] pin_output_en,
  output reg  [NUM_PINS-1:0] pin_digital_en
);

  // ==========================================================
  // Register state
  // Control words as stored; spare bits are masked to zero on write
  reg  [7:0]  ctl0_r;
  reg  [7:0]  ctl1_r;
  reg  [7:0]  ctl2_r;
  reg  [7:0]  bg_r;
  // Captured result, kept through disable and abort
  reg  [11:0] result_r;
  // Sequencer state and start edge detector
  reg         busy_r;
  reg         start_prev_r;
  // Converter clock divider and period counter
  reg  [6:0]  div_cnt_r;
  reg  [4:0]  clk_cnt_r;

  // Field views of the control words
  wire        conv_en = ctl0_r[`AIS_C0_EN];
  wire        fmt = ctl0_r[`AIS_C0_FMT];
  wire [3:0]  chan = ctl0_r[3:0];
  wire [3:0]  src = ctl1_r[7:4];
  wire [2:0]  div_sel = ctl1_r[2:0];

  // Source code decode, used only for the external channel gating in the mux
  function is_external;
    input [3:0] code;
    begin
      is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
    end
  endfunction

  // Divider terminal count: mask of low counter bits per power of two
  function [6:0] div_mask;
    input [2:0] sel;
    begin
      div_mask = (7'h01 << sel) - 7'h01;
    end
  endfunction

  // Channel code to pad switch; reserved and missing codes leave all open
  function [4:0] chan_decode;
    input [3:0] code;
    begin
      case (code)
        4'h0:    chan_decode = 5'h01;
        4'h1:    chan_decode = 5'h02;
        4'h3:    chan_decode = 5'h08;
        4'h4:    chan_decode = 5'h10;
        default: chan_decode = 5'h00;
      endcase
    end
  endfunction

  // Source code to internal tap; external codes give all-zero
  function [6:0] src_decode;
    input [3:0] code;
    begin
      case (code)
        4'h1:    src_decode = 7'h01;
        4'h2:    src_decode = 7'h02;
        4'h3:    src_decode = 7'h04;
        4'h5:    src_decode = 7'h08;
        4'h6:    src_decode = 7'h10;
        4'h7:    src_decode = 7'h20;
        4'h8, 4'h9, 4'ha, 4'hb: src_decode = 7'h40;
        default: src_decode = 7'h00;
      endcase
    end
  endfunction

  // Reference field to switch; both upper codes pick the amplifier
  function [2:0] ref_decode;
    input [1:0] code;
    begin
      case (code)
        2'b00:   ref_decode = 3'h1;
        2'b01:   ref_decode = 3'h2;
        default: ref_decode = 3'h4;
      endcase
    end
  endfunction

  // Start falls after being high: high-then-low begins a conversion
  wire start_fall = start_prev_r && !ctl0_r[`AIS_C0_START];
  // Tick every 2^sel system clocks; sel 0 ticks every cycle
  wire tick = ((div_cnt_r & div_mask(div_sel)) == div_mask(div_sel));

  // ==========================================================
  // Software-visible registers; busy is hardware-owned
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctl0_r <= `AIS_RST_CTL;
      ctl1_r <= `AIS_RST_CTL;
      ctl2_r <= `AIS_RST_CTL;
      bg_r   <= `AIS_RST_CTL;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        `AIS_IDX_CTL_FIRST: ctl0_r <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        `AIS_IDX_SRC_DIV:   ctl1_r <= reg_wdata & `AIS_MASK_C1;
        `AIS_IDX_AMP_REF:   ctl2_r <= reg_wdata & `AIS_MASK_C2;
        `AIS_IDX_BANDGAP:   bg_r   <= reg_wdata & `AIS_MASK_BG;
        // Result and spare indices are read-only
        default:            ctl0_r <= ctl0_r;
      endcase
    end
  end

  // ==========================================================
  // Conversion sequencer: 16 converter clocks, first 4 sampling
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      busy_r       <= 1'b0;
      start_prev_r <= 1'b0;
      div_cnt_r    <= 7'h00;
      clk_cnt_r    <= 5'h00;
      result_r     <= 12'h000;
      core_done    <= 1'b0;
    end
    else if (clk_en)
    begin
      // Remember start for edge detection; done is a one-cycle pulse
      start_prev_r <= ctl0_r[`AIS_C0_START];
      core_done    <= 1'b0;
      // Divider free-runs only while busy so the first period is full length
      if (busy_r)
        div_cnt_r <= div_cnt_r + 7'h01;
      else
        div_cnt_r <= 7'h00;
      if (!conv_en)
      begin
        // Abort; the result bytes keep their old contents
        busy_r    <= 1'b0;
        clk_cnt_r <= 5'h00;
      end
      // A start edge while busy is ignored
      else if (start_fall && !busy_r)
      begin
        busy_r    <= 1'b1;
        clk_cnt_r <= 5'h00;
      end
      else if (busy_r && tick)
      begin
        // Last converter clock: capture the result and release busy
        if (clk_cnt_r == `AIS_TOTAL_CLKS - 5'h01)
        begin
          busy_r    <= 1'b0;
          result_r  <= core_result;
          core_done <= 1'b1;
          clk_cnt_r <= 5'h00;
        end
        else
          clk_cnt_r <= clk_cnt_r + 5'h01;
      end
    end
  end

  // ==========================================================
  // Core strobes, registered for clean timing into the analog side
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      core_power    <= 1'b0;
      core_sample   <= 1'b0;
      core_clk_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      core_power    <= conv_en;
      core_sample   <= busy_r && (clk_cnt_r < `AIS_SAMPLE_CLKS);
      core_clk_tick <= busy_r && tick;
    end
  end

  // ==========================================================
  // Select decode: input multiplexer, one-hot
  // Loop index for the pin overrides further down
  integer i;

  // External path only when the source field picks it, so a pad is never
  // joined to an internal tap whatever the channel code holds
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ext_channel_onehot     <= 5'h00;
      internal_source_onehot <= 7'h00;
    end
    else if (clk_en)
    begin
      // Channel decode gated by the source field
      if (is_external(src))
        ext_channel_onehot <= chan_decode(chan);
      else
        ext_channel_onehot <= 5'h00;
      // Bit0 AVDD,1 AVDD/2,2 AVDD/4,3 VR,4 VR/2,5 VR/4,6 AVSS
      internal_source_onehot <= src_decode(src);
    end
  end

  // ==========================================================
  // Reference switch and amplifier controls
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reference_onehot          <= 3'h0;
      ext_ref_pin_connect       <= 1'b0;
      amplifier_enable          <= 1'b0;
      amp_ref_input_pin_connect <= 1'b0;
      amp_bandgap_connect       <= 1'b0;
      amplifier_gain_onehot     <= 4'h0;
    end
    else if (clk_en)
    begin
      // Bit0 supply, bit1 external pin, bit2 amplifier output
      reference_onehot          <= ref_decode(ctl2_r[3:2]);
      // Pin joins the reference path only for its own code
      ext_ref_pin_connect       <= (ctl2_r[3:2] == 2'b01);
      // Power is left to software; no automatic enable
      amplifier_enable          <= ctl2_r[`AIS_C2_AMPEN];
      // Pin and bandgap are never both on the amplifier input
      amp_ref_input_pin_connect <= !ctl2_r[`AIS_C2_AMPIN];
      amp_bandgap_connect       <= ctl2_r[`AIS_C2_AMPIN];
      amplifier_gain_onehot     <= 4'h1 << ctl2_r[1:0];
    end
  end

  // ==========================================================
  // Bandgap enable; start-up settling is left to software
  always @(posedge mclk)
  begin
    if (!rst_n)
      bandgap_enable <= 1'b0;
    else if (clk_en)
      bandgap_enable <= bg_r[0];
  end

  // ==========================================================
  // Pin overrides: analog function wins over pull-high and direction
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_pull_high  <= {NUM_PINS{1'b0}};
      pin_output_en  <= {NUM_PINS{1'b0}};
      pin_digital_en <= {NUM_PINS{1'b0}};
    end
    else if (clk_en)
    begin
      for (i = 0; i < NUM_PINS; i = i + 1)
      begin
        // Pull-high only while the pin stays digital
        pin_pull_high[i]  <= pin_pull_high_req[i] && !pin_analog_select[i];
        // Analog use overrides the port direction setting
        pin_output_en[i]  <= pin_output_en_req[i] && !pin_analog_select[i];
        // Original pin function dropped while analog
        pin_digital_en[i] <= !pin_analog_select[i];
      end
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe; zero otherwise
  always @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          // Result packing follows the format bit
          `AIS_IDX_RES_LOW:
            reg_rdata <= fmt ? result_r[7:0] : {result_r[3:0], 4'h0};
          `AIS_IDX_RES_HIGH:
            reg_rdata <= fmt ? {4'h0, result_r[11:8]} : result_r[11:4];
          // Control words as stored; busy is read live
          `AIS_IDX_CTL_FIRST: reg_rdata <= {ctl0_r[7], busy_r, ctl0_r[5:0]};
          `AIS_IDX_SRC_DIV:   reg_rdata <= ctl1_r;
          `AIS_IDX_AMP_REF:   reg_rdata <= ctl2_r;
          `AIS_IDX_BANDGAP:   reg_rdata <= bg_r;
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ==== src/ais_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the
// converter control block. Assumes an 8-bit register port with word indices.
// How it works
// - Format bit 0 left-justifies result in two bytes; 1 right-justifies it.
// - Channel field codes 0,1,3,4 pick external channels; code 2 is reserved.
// - Channel codes 5 through 15 select nothing; converter input floats.
// - Source codes 0000, 0100, 11xx convert the selected external channel.
// - Other source codes pick supply, fractions, amplifier taps, or ground.
// - Any internal source disconnects the external channel path entirely.
// - Amplifier input bit picks reference pin or bandgap, dropping the pin.
// - Reference field picks supply, external pin, or amplifier output.
// - Internal reference choice disconnects the external reference pin.
// - Gain field sets gain 1, 1.667, 2.5 or 3.333.
// - Unimplemented control and bandgap bits read back as zero.
// - Bandgap enable bit powers the bandgap; resets to zero.
// - Analog pin function drops original function and pull-high resistor.
// - Analog pin function overrides port direction control.
// - All control fields read zero after reset.
// - Start bit high then low begins conversion; busy set until done.
// - Conversion takes 4 sampling plus 12 converting converter clocks.
// - Converter clock is system clock divided by two to the divider field.
// - Converter disabled leaves both result bytes unchanged.
`ifndef AIS_REGS_VH
`define AIS_REGS_VH

// ==========================================================
// Register indices
`define AIS_IDX_RES_LOW   3'h0
`define AIS_IDX_RES_HIGH  3'h1
`define AIS_IDX_CTL_FIRST 3'h2
`define AIS_IDX_SRC_DIV   3'h3
`define AIS_IDX_AMP_REF   3'h4
`define AIS_IDX_BANDGAP   3'h5

// ==========================================================
// Field positions
`define AIS_C0_START  7
`define AIS_C0_BUSY   6
`define AIS_C0_EN     5
`define AIS_C0_FMT    4
`define AIS_C2_AMPEN  7
`define AIS_C2_AMPIN  4

// ==========================================================
// Reset values and implemented-bit masks
`define AIS_RST_CTL   8'h00
`define AIS_MASK_C1   8'hf7
`define AIS_MASK_C2   8'h9f
`define AIS_MASK_BG   8'h01

// ==========================================================
// Conversion timing in converter clocks
`define AIS_SAMPLE_CLKS  5'h04
`define AIS_TOTAL_CLKS   5'h10

`endif

// ==== test/ais_ctrl_assertions.sv ====
// Checker for converter control selects, pin overrides and read-back.
// Assumes one clock, synchronous active-low reset; bound below.
`timescale 1ns/1ns
module ais_ctrl_assertions #(
  parameter NUM_PINS = 4
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                clk_en,
  // Register port
  input wire logic [2:0]          reg_addr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  // Decoded selects
  input wire logic [4:0]          ext_channel_onehot,
  input wire logic [6:0]          internal_source_onehot,
  input wire logic [2:0]          reference_onehot,
  input wire logic                ext_ref_pin_connect,
  input wire logic                amp_ref_input_pin_connect,
  input wire logic                amp_bandgap_connect,
  input wire logic [3:0]          amplifier_gain_onehot,
  input wire logic                core_done,
  // Pins
  input wire logic [NUM_PINS-1:0] pin_analog_select,
  input wire logic [NUM_PINS-1:0] pin_pull_high_req,
  input wire logic [NUM_PINS-1:0] pin_output_en_req,
  input wire logic [NUM_PINS-1:0] pin_pull_high,
  input wire logic [NUM_PINS-1:0] pin_output_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ====================
  // Read-back and pin steps
  sequence s_rd_bg; reg_rd && clk_en && reg_addr == 3'h5; endsequence
  sequence s_rd_amp; reg_rd && clk_en && reg_addr == 3'h4; endsequence
  // Pins are judged only once a live cycle has passed after reset
  sequence s_live; $past(rst_n) && $past(clk_en); endsequence
  chk_bg_unimpl: assert property (s_rd_bg |=> reg_rdata[7:1] == 7'h00)
    else $error("bandgap spare bits not zero");
  chk_amp_unimpl: assert property (s_rd_amp |=> reg_rdata[6:5] == 2'b00)
    else $error("amp spare bits not zero");
  chk_chan_legal: assert property (
    $onehot0(ext_channel_onehot) && !ext_channel_onehot[2])
    else $error("bad channel select");
  chk_src_excl: assert property (
    |internal_source_onehot |-> ext_channel_onehot == 5'h00)
    else $error("external path joined to internal");
  chk_src_hot: assert property ($onehot0(internal_source_onehot))
    else $error("several internal sources");
  chk_ref_pin: assert property (
    $onehot0(reference_onehot) && ext_ref_pin_connect == reference_onehot[1])
    else $error("ref pin vs select");
  chk_amp_input: assert property (amp_bandgap_connect |-> !amp_ref_input_pin_connect)
    else $error("amp input pin and bandgap both on");
  chk_gain_hot: assert property ($onehot0(amplifier_gain_onehot))
    else $error("gain select not one-hot");
  chk_pin_pull: assert property (
    s_live |-> pin_pull_high == $past(pin_pull_high_req & ~pin_analog_select))
    else $error("pull-high not removed");
  chk_pin_dir: assert property (
    s_live |-> pin_output_en == $past(pin_output_en_req & ~pin_analog_select))
    else $error("direction not overridden");
  chk_done_pulse: assert property (core_done |=> !core_done)
    else $error("done longer than one cycle");
endmodule

bind ais_ctrl ais_ctrl_assertions #(.NUM_PINS(NUM_PINS)) chk_u (.mclk(mclk), .rst_n(rst_n),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_channel_onehot(ext_channel_onehot), .internal_source_onehot(internal_source_onehot),
  .reference_onehot(reference_onehot), .ext_ref_pin_connect(ext_ref_pin_connect),
  .amp_ref_input_pin_connect(amp_ref_input_pin_connect), .core_done(core_done),
  .amp_bandgap_connect(amp_bandgap_connect), .amplifier_gain_onehot(amplifier_gain_onehot),
  .pin_analog_select(pin_analog_select), .pin_pull_high_req(pin_pull_high_req),
  .pin_output_en_req(pin_output_en_req), .pin_pull_high(pin_pull_high),
  .pin_output_en(pin_output_en));

// ==== test/tb_adc_input_reference_select.sv ====
// Self-checking bench for the converter control block.
// Assumes the register header is on the include path.
`timescale 1ns/1ns
`include "ais_regs.vh"
module tb_adc_input_reference_select;
  // ====================
  // Signals
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] core_result = 12'h000;
  logic [3:0]  pin_analog_select = 4'h0;
  logic [3:0]  pin_pull_high_req = 4'h0;
  logic [3:0]  pin_output_en_req = 4'h0;
  logic [7:0]  reg_rdata;
  logic [4:0]  ext_channel_onehot;
  logic [6:0]  internal_source_onehot;
  logic [3:0]  amplifier_gain_onehot, pin_pull_high, pin_output_en, pin_digital_en;
  logic [2:0]  reference_onehot;
  logic        core_power, core_sample, core_clk_tick, core_done, ext_ref_pin_connect;
  logic        amplifier_enable, amp_ref_input_pin_connect, amp_bandgap_connect, bandgap_enable;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
`define AIS_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
  ais_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_result(core_result), .core_power(core_power), .core_sample(core_sample),
    .core_clk_tick(core_clk_tick), .core_done(core_done),
    .ext_channel_onehot(ext_channel_onehot), .internal_source_onehot(internal_source_onehot),
    .reference_onehot(reference_onehot), .ext_ref_pin_connect(ext_ref_pin_connect),
    .amplifier_enable(amplifier_enable), .amp_ref_input_pin_connect(amp_ref_input_pin_connect),
    .amp_bandgap_connect(amp_bandgap_connect), .amplifier_gain_onehot(amplifier_gain_onehot),
    .bandgap_enable(bandgap_enable), .pin_analog_select(pin_analog_select),
    .pin_pull_high_req(pin_pull_high_req), .pin_output_en_req(pin_output_en_req),
    .pin_pull_high(pin_pull_high), .pin_output_en(pin_output_en),
    .pin_digital_en(pin_digital_en));
  // 25 MHz clock and a hang guard well above the few hundred cycles needed
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      end_sim();
    end
  end
  // ====================
  // Bus tasks; strobes last exactly one cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `AIS_CHK(reg_rdata, e)
  endtask
  // Decoded outputs lag the register by one more cycle
  task automatic settle;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  // ====================
  // Scenarios
  task automatic t_regs;
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h4, 8'h00);
    rd(3'h5, 8'h00);
    wr(3'h4, 8'hff);
    wr(3'h5, 8'hff);
    rd(3'h4, 8'h9f);
    rd(3'h5, 8'h01);
    rd(3'h6, 8'h00);
    // A write while the enable is low must not land
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(3'h5, 8'h00);
    clk_en <= 1'b1;
    rd(3'h5, 8'h01);
    `AIS_CHK(bandgap_enable, 1'b1)
    wr(3'h5, 8'h00);
    settle();
    `AIS_CHK(bandgap_enable, 1'b0)
  endtask
  task automatic t_src;
    logic [6:0] e;
    for (int c = 0; c < 16; c++)
    begin
      wr(3'h2, c[7:0]);
      settle();
      `AIS_CHK(ext_channel_onehot, (c < 5 && c != 2) ? 5'h01 << c : 5'h00)
    end
    wr(3'h2, 8'h01);
    for (int s = 0; s < 16; s++)
    begin
      case (s)
        1, 2, 3: e = 7'h01 << (s - 1);
        5, 6, 7: e = 7'h08 << (s - 5);
        8, 9, 10, 11: e = 7'h40;
        default: e = 7'h00;
      endcase
      wr(3'h3, {s[3:0], 4'h0});
      settle();
      `AIS_CHK(internal_source_onehot, e)
      `AIS_CHK(ext_channel_onehot, (e == 7'h00) ? 5'h02 : 5'h00)
    end
  endtask
  task automatic t_ref;
    logic [7:0] d;
    wr(3'h5, 8'h01);
    for (int k = 0; k < 64; k++)
    begin
      d = {k[5] | k[3], 2'b00, k[4:0]};
      wr(3'h4, d);
      settle();
      `AIS_CHK(reference_onehot, d[3] ? 3'h4 : (d[2] ? 3'h2 : 3'h1))
      `AIS_CHK(ext_ref_pin_connect, d[3:2] == 2'b01)
      `AIS_CHK(amplifier_gain_onehot, 4'h1 << d[1:0])
      `AIS_CHK({amp_bandgap_connect, amp_ref_input_pin_connect}, {d[4], !d[4]})
      `AIS_CHK(amplifier_enable, d[7])
    end
  endtask
  task automatic t_pins;
    for (int k = 0; k < 16; k++)
    begin
      @(posedge mclk);
      pin_analog_select <= k[3:0];
      pin_pull_high_req <= 4'hf;
      pin_output_en_req <= 4'h9;
      settle();
      `AIS_CHK(pin_pull_high, ~k[3:0])
      `AIS_CHK(pin_output_en, 4'h9 & ~k[3:0])
      `AIS_CHK(pin_digital_en, ~k[3:0])
    end
  endtask
  // Conversions at divide-by-one and -two, one per format, then an abort
  task automatic t_conv;
    int n;
    int t;
    int s;
    for (int f = 0; f < 2; f++)
    begin
      wr(3'h3, f[7:0]);
      @(posedge mclk);
      core_result <= f ? 12'h5d3 : 12'habc;
      wr(3'h2, 8'ha0 | (f << 4));
      wr(3'h2, 8'h20 | (f << 4));
      n = 0;
      t = 0;
      s = 0;
      while (core_done !== 1'b1 && n < 200)
      begin
        @(negedge mclk);
        n++;
        t += core_clk_tick;
        s += core_sample;
      end
      `AIS_CHK(t, 16)
      `AIS_CHK(s, 4 << f)
      `AIS_CHK(n, f ? 34 : 18)
      `AIS_CHK(core_power, 1'b1)
      rd(3'h2, 8'h20 | (f << 4));
      rd(3'h1, f ? 8'h05 : 8'hab);
      rd(3'h0, f ? 8'hd3 : 8'hc0);
    end
    @(posedge mclk);
    core_result <= 12'h000;
    wr(3'h2, 8'hb0);
    wr(3'h2, 8'h30);
    rd(3'h2, 8'h70);
    wr(3'h2, 8'h10);
    repeat (40) @(posedge mclk);
    rd(3'h2, 8'h10);
    rd(3'h0, 8'hd3);
    rd(3'h1, 8'h05);
    `AIS_CHK(core_power, 1'b0)
  endtask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_src();
    t_ref();
    t_pins();
    t_conv();
    end_sim();
  end
endmodule
